// [verilog/gtm_timer.sv]
// sixteen bit gated timer with apb registers
`timescale 1ns/1ns
`include "gtm_map.svh"

module gtm_timer (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire gtm_pkg::gtm_apb_s apb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins and on-chip sources
	input wire gtm_pkg::gtm_pins_s pins,
	input wire logic sleep_mode,
	// interrupt and wake
	output logic irq,
	output logic wake
);
	import gtm_pkg::*;

	logic [15:0] count;
	logic [7:0] ctrl;
	logic [7:0] gate;
	logic [1:0] status;
	logic [1:0] mask;
	logic [2:0] pre_cnt;
	logic [1:0] instr_cnt;
	gtm_arm_e arm;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_irq;
	logic next_wake;
	logic [15:0] next_count;
	logic [7:0] next_ctrl;
	logic [7:0] next_gate;
	logic [1:0] next_status;
	logic [1:0] next_mask;
	logic [2:0] next_pre_cnt;
	logic [1:0] next_instr_cnt;
	gtm_arm_e next_arm;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int NSRC = 6;
	logic [NSRC-1:0] raw;
	logic [NSRC-1:0] lvl;
	logic [NSRC-1:0] rise;
	logic [NSRC-1:0] fall;
	assign raw = {pins.cmp2_out, pins.cmp1_out, pins.gate_pin,
		pins.cap_osc, pins.crystal_in_pin, pins.ext_count_pin};

	// every pin passes two flops before any logic sees it
	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_sync
			gtm_edge u_edge (
				.pclk(pclk),
				.presetn(presetn),
				.din(raw[gi]),
				.level(lvl[gi]),
				.rise(rise[gi]),
				.fall(fall[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic wr;
	logic rd;
	logic mapped;
	assign wr = apb.psel & apb.penable & apb.pwrite & ~pready;
	assign rd = apb.psel & apb.penable & ~apb.pwrite & ~pready;
	always_comb begin
		case (apb.paddr)
			`GTM_OFF_CNT_LOW, `GTM_OFF_CNT_HIGH, `GTM_OFF_CTRL,
			`GTM_OFF_GATE, `GTM_OFF_STATUS, `GTM_OFF_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	logic wr_lo;
	logic wr_hi;
	assign wr_lo = wr & (apb.paddr == `GTM_OFF_CNT_LOW);
	assign wr_hi = wr & (apb.paddr == `GTM_OFF_CNT_HIGH);

	// ----------------------------------------
	// source selection and count enable
	// ----------------------------------------
	logic run;
	logic osc_en;
	logic async_md;
	gtm_src_e src;
	logic [1:0] pre_sel;
	assign run = ctrl[`GTM_CTRL_RUN];
	assign async_md = ctrl[`GTM_CTRL_SYNC_N];
	assign osc_en = ctrl[`GTM_CTRL_OSC_EN];
	assign pre_sel = ctrl[`GTM_CTRL_PRE_LO +: 2];
	assign src = gtm_src_e'(ctrl[`GTM_CTRL_SRC_LO +: 2]);

	// gate source mux: pin, comparator one, comparator two
	logic gate_raw;
	logic gate_ok;
	always_comb begin
		case (gate[`GTM_GATE_SEL_LO +: 2])
			2'h1: gate_raw = lvl[4];
			2'h2: gate_raw = lvl[5];
			default: gate_raw = lvl[3];
		endcase
	end
	assign gate_ok = gate_raw ~^ gate[`GTM_GATE_POL];

	// run off stops; gate enable only narrows counting when run is on
	logic cnt_en;
	assign cnt_en = run & (~gate[`GTM_GATE_EN] | gate_ok);

	// external edge source: pin, crystal when the oscillator is on, or the sensing oscillator
	logic ext_is_pin;
	logic ext_rise;
	logic ext_fall;
	logic ext_lvl;
	logic is_ext;
	assign ext_is_pin = (src == GTM_SRC_EXT) & ~osc_en;
	assign is_ext = (src == GTM_SRC_EXT) | (src == GTM_SRC_CAP);
	always_comb begin
		if (src == GTM_SRC_CAP) begin
			ext_rise = rise[2];
			ext_fall = fall[2];
			ext_lvl = lvl[2];
		end else if (ext_is_pin) begin
			ext_rise = rise[0];
			ext_fall = fall[0];
			ext_lvl = lvl[0];
		end else begin
			ext_rise = rise[1];
			ext_fall = fall[1];
			ext_lvl = lvl[1];
		end
	end

	// ----------------------------------------
	// tick generation
	// ----------------------------------------
	// async mode is emulated on pclk: edges count even while asleep, which
	// the synchronised mode suppresses; both still pass the synchroniser
	logic first_ok;
	logic src_tick;
	always_comb begin
		case (src)
			GTM_SRC_SYS: src_tick = 1'b1;
			GTM_SRC_INSTR: src_tick = (instr_cnt == 2'h3);
			default: src_tick = ext_rise & first_ok &
				(async_md | ~sleep_mode);
		endcase
	end
	// first counted rise needs a prior falling edge in counter mode
	assign first_ok = ~ext_is_pin | (arm == GTM_ARM_READY);

	logic pre_tick;
	assign pre_tick = cnt_en & src_tick &
		((pre_cnt & ((3'h1 << pre_sel) - 3'h1)) ==
		((3'h1 << pre_sel) - 3'h1));

	// ----------------------------------------
	// next state for counter, prescaler, arming
	// ----------------------------------------
	logic ovf;
	always_comb begin
		next_count = count;
		next_pre_cnt = pre_cnt;
		next_instr_cnt = instr_cnt + 2'h1; // one instruction per four clocks
		next_arm = arm;
		ovf = 1'b0;
		if (cnt_en && src_tick) begin
			next_pre_cnt = pre_cnt + 3'h1;
		end
		if (pre_tick) begin
			next_count = count + 16'h0001;
			ovf = (count == 16'hffff);
		end
		// a byte write replaces the live count and restarts the prescaler
		if (wr_lo) begin
			next_count[7:0] = apb.pwdata[7:0];
			next_pre_cnt = 3'h0;
		end
		if (wr_hi) begin
			next_count[15:8] = apb.pwdata[7:0];
			next_pre_cnt = 3'h0;
		end
		// arming: lost on disable or write, regained on a falling edge
		case (arm)
			GTM_ARM_WAIT: begin
				if (run && ext_fall) begin
					next_arm = GTM_ARM_READY;
				end
			end
			GTM_ARM_READY: begin
				if (!run || wr_lo || wr_hi) begin
					next_arm = GTM_ARM_WAIT;
				end
			end
			default: next_arm = GTM_ARM_WAIT;
		endcase
	end

	// ----------------------------------------
	// next state for registers and bus answer
	// ----------------------------------------
	always_comb begin
		next_ctrl = ctrl;
		next_gate = gate;
		next_mask = mask;
		next_status = status;
		// hardware set wins over a write-one clear in the same cycle
		if (wr && apb.paddr == `GTM_OFF_STATUS) begin
			next_status = status & ~apb.pwdata[1:0];
		end
		if (ovf) begin
			next_status[`GTM_ST_OVF] = 1'b1;
		end
		if (ovf && sleep_mode && async_md && is_ext) begin
			next_status[`GTM_ST_WAKE] = 1'b1;
		end
		if (wr && apb.paddr == `GTM_OFF_CTRL) begin
			next_ctrl = apb.pwdata[7:0];
		end
		if (wr && apb.paddr == `GTM_OFF_GATE) begin
			next_gate = apb.pwdata[7:0] & ~(8'h01 << `GTM_GATE_VAL);
		end
		if (wr && apb.paddr == `GTM_OFF_MASK) begin
			next_mask = apb.pwdata[1:0];
		end
		next_pready = apb.psel & apb.penable & ~pready;
		next_pslverr = apb.psel & apb.penable & ~pready & ~mapped;
		next_prdata = 32'h0000_0000;
		if (rd) begin
			case (apb.paddr)
				`GTM_OFF_CNT_LOW: next_prdata = {24'h0, count[7:0]};
				`GTM_OFF_CNT_HIGH: next_prdata = {24'h0, count[15:8]};
				`GTM_OFF_CTRL: next_prdata = {24'h0, ctrl};
				`GTM_OFF_GATE: next_prdata = {24'h0,
					gate | (8'(gate_ok) << `GTM_GATE_VAL)};
				`GTM_OFF_STATUS: next_prdata = {30'h0, status};
				`GTM_OFF_MASK: next_prdata = {30'h0, mask};
				default: next_prdata = 32'h0000_0000;
			endcase
		end
		next_irq = |(next_status & next_mask);
		next_wake = next_status[`GTM_ST_WAKE] & next_mask[`GTM_ST_WAKE];
	end

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 16'h0000;
			ctrl <= `GTM_CTRL_RST;
			gate <= `GTM_GATE_RST;
			status <= 2'h0;
			mask <= 2'h0;
			pre_cnt <= 3'h0;
			instr_cnt <= 2'h0;
			arm <= GTM_ARM_WAIT;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
			wake <= 1'b0;
		end else begin
			count <= next_count;
			ctrl <= next_ctrl;
			gate <= next_gate;
			status <= next_status;
			mask <= next_mask;
			pre_cnt <= next_pre_cnt;
			instr_cnt <= next_instr_cnt;
			arm <= next_arm;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			irq <= next_irq;
			wake <= next_wake;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_run_off_holds;
		@(posedge pclk) disable iff (!presetn)
		(!run && !wr_lo && !wr_hi) |=> (count == $past(count));
	endproperty
	a_run_off_holds: assert property (p_run_off_holds)
		else $error("count moved while run bit clear");

	property p_sys_counts;
		@(posedge pclk) disable iff (!presetn)
		(run && !gate[`GTM_GATE_EN] && src == GTM_SRC_SYS && pre_sel == 2'h0
		&& !wr_lo && !wr_hi) |=> (count == $past(count) + 16'h0001);
	endproperty
	a_sys_counts: assert property (p_sys_counts)
		else $error("system clock source did not count each clock");

	property p_write_low;
		@(posedge pclk) disable iff (!presetn)
		wr_lo |=> (count[7:0] == $past(apb.pwdata[7:0]));
	endproperty
	a_write_low: assert property (p_write_low)
		else $error("low byte write not applied");

	property p_write_high;
		@(posedge pclk) disable iff (!presetn)
		wr_hi |=> (count[15:8] == $past(apb.pwdata[7:0]));
	endproperty
	a_write_high: assert property (p_write_high)
		else $error("high byte write not applied");

	property p_pre_clear;
		@(posedge pclk) disable iff (!presetn)
		(wr_lo || wr_hi) |=> (pre_cnt == 3'h0);
	endproperty
	a_pre_clear: assert property (p_pre_clear)
		else $error("prescaler not cleared by count write");

	property p_unarmed_no_count;
		@(posedge pclk) disable iff (!presetn)
		(ext_is_pin && arm == GTM_ARM_WAIT && !wr_lo && !wr_hi)
		|=> (count == $past(count));
	endproperty
	a_unarmed_no_count: assert property (p_unarmed_no_count)
		else $error("counted before a falling edge was seen");

	property p_ovf_flag;
		@(posedge pclk) disable iff (!presetn)
		ovf |=> status[`GTM_ST_OVF];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag)
		else $error("overflow did not set its flag");

	sequence s_instr_run;
		(run && !gate[`GTM_GATE_EN] && src == GTM_SRC_INSTR &&
		pre_sel == 2'h0 && !wr_lo && !wr_hi) [*4];
	endsequence
	property p_instr_rate;
		@(posedge pclk) disable iff (!presetn)
		s_instr_run |=> (count == $past(count, 4) + 16'h0001);
	endproperty
	a_instr_rate: assert property (p_instr_rate)
		else $error("instruction clock did not count once per four");

endmodule : gtm_timer

// [verilog/gtm_map.svh]
// register offsets, field positions, reset values and timing for the timer
`ifndef GTM_MAP_SVH
`define GTM_MAP_SVH

// byte offsets on the apb bus
`define GTM_OFF_CNT_LOW 12'h000
`define GTM_OFF_CNT_HIGH 12'h004
`define GTM_OFF_CTRL 12'h008
`define GTM_OFF_GATE 12'h00c
`define GTM_OFF_STATUS 12'h010
`define GTM_OFF_MASK 12'h014

// timer_control_reg fields
`define GTM_CTRL_RUN 0
`define GTM_CTRL_SYNC_N 1
`define GTM_CTRL_OSC_EN 2
`define GTM_CTRL_PRE_LO 4
`define GTM_CTRL_SRC_LO 6
`define GTM_CTRL_RST 8'h00

// gate_control_reg fields
`define GTM_GATE_EN 7
`define GTM_GATE_POL 6
`define GTM_GATE_VAL 2
`define GTM_GATE_SEL_LO 0
`define GTM_GATE_RST 8'h00

// status and mask bits
`define GTM_ST_OVF 0
`define GTM_ST_WAKE 1

// instruction clock is the system clock divided by this
`define GTM_INSTR_DIV 4

`endif

// [verilog/gtm_pkg.sv]
// types shared by the gated timer files
package gtm_pkg;

	// count clock source field codes
	typedef enum logic [1:0] {
		GTM_SRC_INSTR = 2'h0,
		GTM_SRC_SYS = 2'h1,
		GTM_SRC_EXT = 2'h2,
		GTM_SRC_CAP = 2'h3
	} gtm_src_e;

	// external pins and on-chip signals reaching the timer
	typedef struct packed {
		logic ext_count_pin;
		logic crystal_in_pin;
		logic cap_osc;
		logic gate_pin;
		logic cmp1_out;
		logic cmp2_out;
	} gtm_pins_s;

	// apb request carrier
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} gtm_apb_s;

	// first-falling-edge arming state machine
	typedef enum logic [1:0] {
		GTM_ARM_WAIT = 2'b01,
		GTM_ARM_READY = 2'b10
	} gtm_arm_e;

endpackage : gtm_pkg

// [verilog/gtm_edge.sv]
// two-flop synchroniser with a rising and falling edge detector
`timescale 1ns/1ns

module gtm_edge (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// asynchronous level in
	input wire logic din,
	// synchronised level and edges out
	output logic level,
	output logic rise,
	output logic fall
);

	logic meta;
	logic sync;
	logic prev;
	logic next_meta;
	logic next_sync;
	logic next_prev;

	// ----------------------------------------
	// synchroniser and edge history
	// ----------------------------------------
	always_comb begin
		next_meta = din;
		next_sync = meta;
		next_prev = sync;
	end

	// the first flop feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= next_meta;
			sync <= next_sync;
			prev <= next_prev;
		end
	end

	assign level = sync;
	assign rise = sync & ~prev;
	assign fall = ~sync & prev;

endmodule : gtm_edge

// [tb/gtm_pins_model.sv]
// far side model: count, crystal, sensing and gate lines
`timescale 1ns/1ns

module gtm_pins_model (
	// clock used only to pace the edges
	input wire logic pclk,
	// lines toward the timer
	output gtm_pkg::gtm_pins_s pins
);
	import gtm_pkg::*;

	// -----------------------------------------------
	// line drivers
	// -----------------------------------------------
	// lines rest low and stand still between bursts
	initial begin
		pins = '0;
	end

	// idx 5 count pin, 4 crystal, 3 sensing osc, 2 gate pin, 1..0 cmp
	// gate lines change freely, unrelated to the count clock
	task automatic set_line(input int idx, input logic v);
		@(posedge pclk);
		pins[idx] <= v;
	endtask : set_line

	// full periods; each level held 4 cycles so the synchroniser sees it
	// a crystal behaves here like any slow square wave
	task automatic pulse(input int idx, input int n);
		for (int i = 0; i < n; i++) begin
			set_line(idx, 1'b1);
			repeat (3) @(posedge pclk);
			set_line(idx, 1'b0);
			repeat (3) @(posedge pclk);
		end
	endtask : pulse
endmodule : gtm_pins_model

// [tb/sixteen_bit_gated_timer_tb_top.sv]
// self-checking bench for the gated timer
`timescale 1ns/1ns
`include "gtm_map.svh"

module sixteen_bit_gated_timer_tb_top;
	import gtm_pkg::*;

	logic pclk;
	logic presetn;
	gtm_apb_s apb;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	gtm_pins_s pins;
	logic sleep_mode;
	logic irq;
	logic wake;
	logic [31:0] rd;
	logic err_bit;
	int errors = 0;
	int checked = 0;
	int cyc = 0;

	gtm_timer gtm_timer_inst (.pclk(pclk), .presetn(presetn), .apb(apb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
		.sleep_mode(sleep_mode), .irq(irq), .wake(wake));
	gtm_pins_model gtm_pins_model_inst (.pclk(pclk), .pins(pins));

	// -----------------------------------------------
	// clock, cycle count, watchdog
	// -----------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	// whole run needs about 2700 cycles
	initial begin
		repeat (30000) @(posedge pclk);
		errors++;
		report_and_stop();
	end

	// -----------------------------------------------
	// shared tasks
	// -----------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	// one apb transfer; pready sampled at the edge, request held until then
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		apb.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err_bit = pslverr;
		if (n >= 50)
			errors++;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	// counts gained over exactly 128 cycles, both reads equally placed
	task automatic measure(output logic [7:0] delta);
		int c0;
		logic [7:0] first;
		c0 = cyc;
		xfer(1'b0, `GTM_OFF_CNT_LOW, '0);
		first = rd[7:0];
		while (cyc < c0 + 128) @(posedge pclk);
		xfer(1'b0, `GTM_OFF_CNT_LOW, '0);
		delta = rd[7:0] - first;
	endtask : measure

	// -----------------------------------------------
	// scenarios
	// -----------------------------------------------
	task automatic t_regs();
		logic [11:0] a[6];
		a = '{`GTM_OFF_CNT_LOW, `GTM_OFF_CNT_HIGH, `GTM_OFF_CTRL,
			`GTM_OFF_GATE, `GTM_OFF_STATUS, `GTM_OFF_MASK};
		foreach (a[i]) begin
			xfer(1'b0, a[i], '0);
			// idle gate pin with low polarity reads as gate open
			check(rd, (a[i] == `GTM_OFF_GATE) ? 32'h4 : 32'h0);
		end
		xfer(1'b0, 12'h020, '0);
		check({rd[30:0], err_bit}, 32'h1);
		wr(`GTM_OFF_CNT_LOW, 32'ha5);
		wr(`GTM_OFF_CNT_HIGH, 32'h5a);
		xfer(1'b0, `GTM_OFF_CNT_LOW, '0);
		check(rd, 32'ha5);
		xfer(1'b0, `GTM_OFF_CNT_HIGH, '0);
		check(rd, 32'h5a);
	endtask : t_regs

	// source 0 instruction clock, 1 system clock, all four prescales
	task automatic t_rates();
		logic [7:0] d;
		for (int s = 0; s < 2; s++)
			for (int p = 0; p < 4; p++) begin
				wr(`GTM_OFF_CTRL, 32'((s << 6) | (p << 4) | 1));
				wr(`GTM_OFF_CNT_LOW, 32'h0);
				measure(d);
				check(d, 32'(128 >> (p + 2 * (1 - s))));
			end
	endtask : t_rates

	// gate high-polarity on each source; run off stops everything
	task automatic t_gate();
		logic [7:0] d;
		wr(`GTM_OFF_CTRL, 32'h40);
		wr(`GTM_OFF_GATE, 32'h80);
		measure(d);
		check(d, 32'h0);
		wr(`GTM_OFF_CTRL, 32'h41);
		for (int g = 0; g < 3; g++) begin
			wr(`GTM_OFF_GATE, 32'(8'hc0 | g));
			for (int v = 0; v < 2; v++) begin
				gtm_pins_model_inst.set_line(2 - g, v[0]);
				repeat (8) @(posedge pclk);
				measure(d);
				check(d, 32'(128 * v));
				xfer(1'b0, `GTM_OFF_GATE, '0);
				check(rd, 32'(8'hc0 | g | (v << 2)));
			end
			gtm_pins_model_inst.set_line(2 - g, 1'b0);
		end
		// the gate value bit is read only: a written one must not stick
		wr(`GTM_OFF_GATE, 32'h44);
		xfer(1'b0, `GTM_OFF_GATE, '0);
		check(rd, 32'h40);
		wr(`GTM_OFF_GATE, 32'h0);
	endtask : t_gate

	// five pulses after a count write; only the count pin needs arming
	task automatic t_ext();
		logic [7:0] ctl[6] = '{8'h81, 8'h85, 8'h85, 8'hc1, 8'h81, 8'h83};
		int idx[6] = '{5, 4, 5, 3, 5, 5};
		logic sl[6] = '{0, 0, 0, 0, 1, 1};
		logic [7:0] exp[6] = '{4, 5, 0, 5, 0, 4};
		foreach (ctl[i]) begin
			sleep_mode <= sl[i];
			wr(`GTM_OFF_CTRL, 32'(ctl[i]));
			wr(`GTM_OFF_CNT_LOW, 32'h0);
			wr(`GTM_OFF_CNT_HIGH, 32'h0);
			gtm_pins_model_inst.pulse(idx[i], 5);
			repeat (8) @(posedge pclk);
			xfer(1'b0, `GTM_OFF_CNT_LOW, '0);
			check(rd, 32'(exp[i]));
		end
		sleep_mode <= 1'b0;
	endtask : t_ext

	task automatic t_irq();
		wr(`GTM_OFF_STATUS, 32'h3);
		wr(`GTM_OFF_CTRL, 32'h41);
		wr(`GTM_OFF_CNT_HIGH, 32'hff);
		wr(`GTM_OFF_CNT_LOW, 32'hf0);
		repeat (40) @(posedge pclk);
		xfer(1'b0, `GTM_OFF_STATUS, '0);
		check({rd[30:0], irq}, 32'h2);
		wr(`GTM_OFF_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		check(irq, 1'b1);
		wr(`GTM_OFF_STATUS, 32'h1);
		repeat (2) @(posedge pclk);
		check(irq, 1'b0);
		// overflow while asleep on the asynchronous pin wakes the system
		sleep_mode <= 1'b1;
		wr(`GTM_OFF_CTRL, 32'h83);
		wr(`GTM_OFF_CNT_HIGH, 32'hff);
		wr(`GTM_OFF_CNT_LOW, 32'hfe);
		wr(`GTM_OFF_STATUS, 32'h3);
		wr(`GTM_OFF_MASK, 32'h2);
		gtm_pins_model_inst.pulse(5, 5);
		repeat (8) @(posedge pclk);
		check({wake, irq}, 2'b11);
		xfer(1'b0, `GTM_OFF_STATUS, '0);
		check(rd, 32'h3);
		sleep_mode <= 1'b0;
	endtask : t_irq

	// -----------------------------------------------
	// main sequence
	// -----------------------------------------------
	initial begin
		presetn = 1'b0;
		apb = '0;
		sleep_mode = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_rates();
		t_gate();
		t_ext();
		t_irq();
		report_and_stop();
	end
endmodule : sixteen_bit_gated_timer_tb_top
